// file: design/low_power_mode_control.v
// Contract
// (R1) With standby select clear, a sleep request in active mode enters sleep mode.
// (R2) With standby select clear, a sleep request in subactive mode enters subsleep mode.
// (R3) With standby select set, a sleep request in active mode enters standby or watch mode.
// (R4) With standby select set, a sleep request in subactive mode enters watch mode.
// (R5) The medium speed bit selects medium-speed active instead of high-speed active.
// (R6) A low speed bit runs the CPU from the subclock and a 3-bit field picks the settling wait.
`timescale 1ns/100ps
`default_nettype none
`include "lpm_consts.vh"
module low_power_mode_control (
	input wire clk,
	input wire rst,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	input wire sleep_exec,
	input wire wake_event,
	input wire watch_timer_on,
	output reg [2:0] power_mode,
	output reg cpu_on_subclock,
	output reg [17:0] settle_states,
	output reg [1:0] subactive_div,
	output reg noise_sample_fast,
	output reg direct_transfer_on
);
	// ==========================================
	// Mode codes
	// Binary state codes, the same codes that leave on the mode output
	localparam [2:0] ST_ACTIVE_HI = `MODE_ACTIVE_HI;
	localparam [2:0] ST_ACTIVE_MED = `MODE_ACTIVE_MED;
	localparam [2:0] ST_SUBACTIVE = `MODE_SUBACTIVE;
	localparam [2:0] ST_SLEEP = `MODE_SLEEP;
	localparam [2:0] ST_SUBSLEEP = `MODE_SUBSLEEP;
	localparam [2:0] ST_STANDBY = `MODE_STANDBY;
	localparam [2:0] ST_WATCH = `MODE_WATCH;

	// ==========================================
	// Reset images
	// Writable bits clear at reset, so the image is the fixed-one mask
	localparam [7:0] SC1_RESET = `SC1_RSVD;
	localparam [7:0] SC2_RESET = `SC2_RSVD;
	// Bus value outside an answer cycle
	localparam [7:0] READ_IDLE = `RDATA_IDLE;

	// ==========================================
	// Register state
	// System control one fields
	reg software_standby_select;
	reg [2:0] standby_wait_sel;
	reg low_speed_cpu_clock_select;
	// System control two fields
	reg noise_sel;
	reg direct_on;
	reg medium_speed_select;
	reg [1:0] subactive_div_sel;

	// ==========================================
	// Next values
	// Register fields after this edge
	reg next_software_standby_select;
	reg [2:0] next_standby_wait_sel;
	reg next_low_speed_cpu_clock_select;
	reg next_noise_sel;
	reg next_direct_on;
	reg next_medium_speed_select;
	reg [1:0] next_subactive_div_sel;
	// Bus answer and mode
	reg [7:0] next_rdata;
	reg [2:0] next_mode;
	reg [2:0] run_mode;
	// Output copies
	reg next_cpu_on_subclock;
	reg [17:0] next_settle_states;
	reg [1:0] next_subactive_div;
	reg next_noise_sample_fast;
	reg next_direct_transfer_on;

	// ==========================================
	// Helper functions
	// Address decode, shared by the write and read paths
	function hit_sysctl1;
		input [3:0] a;
		begin
			hit_sysctl1 = (a == `ADDR_SYSCTL1);
		end
	endfunction

	function hit_sysctl2;
		input [3:0] a;
		begin
			hit_sysctl2 = (a == `ADDR_SYSCTL2);
		end
	endfunction

	// Wait count from the select field; top bit set means longest wait
	function [17:0] wait_count;
		input [2:0] sel;
		begin
			if (sel[`WAIT_SEL_TOP]) wait_count = `WAIT_128K;
			else if (sel[1:0] == `WAIT_CODE_8K) wait_count = `WAIT_8K;
			else if (sel[1:0] == `WAIT_CODE_16K) wait_count = `WAIT_16K;
			else if (sel[1:0] == `WAIT_CODE_32K) wait_count = `WAIT_32K;
			else wait_count = `WAIT_64K;
		end
	endfunction

	// Awake flavour chosen by the speed bits; low speed outranks medium
	function [2:0] awake_mode;
		input lspd;
		input mspd;
		begin
			if (lspd) awake_mode = ST_SUBACTIVE; // [R6]
			else if (mspd) awake_mode = ST_ACTIVE_MED; // [R5]
			else awake_mode = ST_ACTIVE_HI;
		end
	endfunction

	// Destination of a sleep request taken in an awake mode
	function [2:0] sleep_target;
		input [2:0] mode;
		input stby;
		input watch_on;
		begin
			if (mode == ST_SUBACTIVE) begin
				if (!stby) sleep_target = ST_SUBSLEEP; // [R2]
				else sleep_target = ST_WATCH; // [R4]
			end else begin
				if (!stby) sleep_target = ST_SLEEP; // [R1]
				else if (watch_on) sleep_target = ST_WATCH; // [R3]
				else sleep_target = ST_STANDBY; // [R3]
			end
		end
	endfunction

	// Read image of system control one; fixed bits read as one
	function [7:0] pack_sysctl1;
		input stby;
		input [2:0] wsel;
		input lspd;
		begin
			pack_sysctl1 = `SC1_RSVD;
			pack_sysctl1[`SC1_STBY_BIT] = stby;
			pack_sysctl1[`SC1_WAIT_HI:`SC1_WAIT_LO] = wsel;
			pack_sysctl1[`SC1_LSPD_BIT] = lspd;
		end
	endfunction

	// Read image of system control two; fixed bits read as one
	function [7:0] pack_sysctl2;
		input noise;
		input direct;
		input mspd;
		input [1:0] div;
		begin
			pack_sysctl2 = `SC2_RSVD;
			pack_sysctl2[`SC2_NOISE_BIT] = noise;
			pack_sysctl2[`SC2_DIRECT_BIT] = direct;
			pack_sysctl2[`SC2_MSPD_BIT] = mspd;
			pack_sysctl2[`SC2_DIV_HI:`SC2_DIV_LO] = div;
		end
	endfunction

	// ==========================================
	// Register writes
	// Decode one write; any other address leaves every field alone
	always @* begin
		next_software_standby_select = software_standby_select;
		next_standby_wait_sel = standby_wait_sel;
		next_low_speed_cpu_clock_select = low_speed_cpu_clock_select;
		next_noise_sel = noise_sel;
		next_direct_on = direct_on;
		next_medium_speed_select = medium_speed_select;
		next_subactive_div_sel = subactive_div_sel;
		if (wr) begin
			if (hit_sysctl1(addr)) begin
				next_software_standby_select = wdata[`SC1_STBY_BIT]; // [R1] [R3]
				next_standby_wait_sel = wdata[`SC1_WAIT_HI:`SC1_WAIT_LO]; // [R6]
				next_low_speed_cpu_clock_select = wdata[`SC1_LSPD_BIT]; // [R6]
			end else if (hit_sysctl2(addr)) begin
				next_noise_sel = wdata[`SC2_NOISE_BIT];
				next_direct_on = wdata[`SC2_DIRECT_BIT];
				next_medium_speed_select = wdata[`SC2_MSPD_BIT]; // [R5]
				next_subactive_div_sel = wdata[`SC2_DIV_HI:`SC2_DIV_LO];
			end
		end
	end

	// System control one fields
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			software_standby_select <= SC1_RESET[`SC1_STBY_BIT];
			standby_wait_sel <= SC1_RESET[`SC1_WAIT_HI:`SC1_WAIT_LO];
			low_speed_cpu_clock_select <= SC1_RESET[`SC1_LSPD_BIT];
		end else begin
			software_standby_select <= next_software_standby_select;
			standby_wait_sel <= next_standby_wait_sel;
			low_speed_cpu_clock_select <= next_low_speed_cpu_clock_select;
		end
	end

	// System control two fields
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			noise_sel <= SC2_RESET[`SC2_NOISE_BIT];
			direct_on <= SC2_RESET[`SC2_DIRECT_BIT];
			medium_speed_select <= SC2_RESET[`SC2_MSPD_BIT];
			subactive_div_sel <= SC2_RESET[`SC2_DIV_HI:`SC2_DIV_LO];
		end else begin
			noise_sel <= next_noise_sel;
			direct_on <= next_direct_on;
			medium_speed_select <= next_medium_speed_select;
			subactive_div_sel <= next_subactive_div_sel;
		end
	end

	// ==========================================
	// Register reads
	// Answer stands one cycle only; idle and unmapped cycles read zero
	always @* begin
		next_rdata = READ_IDLE;
		if (rd) begin
			if (hit_sysctl1(addr)) begin
				next_rdata = pack_sysctl1(software_standby_select, standby_wait_sel,
					low_speed_cpu_clock_select);
			end else if (hit_sysctl2(addr)) begin
				next_rdata = pack_sysctl2(noise_sel, direct_on, medium_speed_select,
					subactive_div_sel);
			end
		end
	end

	// Read data register
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= READ_IDLE;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ==========================================
	// Mode sequencing
	// Awake modes follow the speed bits on the next edge; low-power modes hold until a wake
	always @* begin
		run_mode = awake_mode(low_speed_cpu_clock_select, medium_speed_select);
		next_mode = power_mode;
		case (power_mode)
			ST_ACTIVE_HI, ST_ACTIVE_MED, ST_SUBACTIVE: begin
				if (sleep_exec) begin
					next_mode = sleep_target(power_mode, software_standby_select,
						watch_timer_on); // [R1] [R2] [R3] [R4]
				end else begin
					next_mode = run_mode; // [R5]
				end
			end
			ST_SLEEP, ST_SUBSLEEP, ST_STANDBY, ST_WATCH: begin
				// Sleep requests are ignored while already asleep
				if (wake_event) begin
					next_mode = run_mode;
				end
			end
			default: begin
				// Unused code; fall back to the reset mode
				next_mode = ST_ACTIVE_HI;
			end
		endcase
	end

	// Mode register
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			power_mode <= ST_ACTIVE_HI;
		end else begin
			power_mode <= next_mode;
		end
	end

	// ==========================================
	// Output copies
	// One register stage on every output keeps them glitch free
	always @* begin
		next_cpu_on_subclock = low_speed_cpu_clock_select; // [R6]
		next_settle_states = wait_count(standby_wait_sel); // [R6]
		next_subactive_div = subactive_div_sel;
		next_noise_sample_fast = noise_sel;
		next_direct_transfer_on = direct_on;
	end

	// Clock and wait outputs; the wait is a figure only, nothing counts it here
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_on_subclock <= SC1_RESET[`SC1_LSPD_BIT];
			settle_states <= `WAIT_8K;
		end else begin
			cpu_on_subclock <= next_cpu_on_subclock;
			settle_states <= next_settle_states;
		end
	end

	// Divider, noise and transfer outputs
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			subactive_div <= SC2_RESET[`SC2_DIV_HI:`SC2_DIV_LO];
			noise_sample_fast <= SC2_RESET[`SC2_NOISE_BIT];
			direct_transfer_on <= SC2_RESET[`SC2_DIRECT_BIT];
		end else begin
			subactive_div <= next_subactive_div;
			noise_sample_fast <= next_noise_sample_fast;
			direct_transfer_on <= next_direct_transfer_on;
		end
	end
endmodule // low_power_mode_control
`default_nettype wire

// file: inc/lpm_consts.vh
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH
// ==========================================
// Register map (offsets of our own)
`define ADDR_SYSCTL1 4'h0
`define ADDR_SYSCTL2 4'h1
// ==========================================
// System control one fields
`define SC1_STBY_BIT 7
`define SC1_WAIT_HI 6
`define SC1_WAIT_LO 4
`define SC1_LSPD_BIT 3
`define SC1_RSVD 8'h07
// ==========================================
// System control two fields
`define SC2_NOISE_BIT 4
`define SC2_DIRECT_BIT 3
`define SC2_MSPD_BIT 2
`define SC2_DIV_HI 1
`define SC2_DIV_LO 0
`define SC2_RSVD 8'hE0
// ==========================================
// Power modes
`define MODE_ACTIVE_HI 3'h0
`define MODE_ACTIVE_MED 3'h1
`define MODE_SUBACTIVE 3'h2
`define MODE_SLEEP 3'h3
`define MODE_SUBSLEEP 3'h4
`define MODE_STANDBY 3'h5
`define MODE_WATCH 3'h6
// ==========================================
// Settling wait counts in states
`define WAIT_8K 18'h02000
`define WAIT_16K 18'h04000
`define WAIT_32K 18'h08000
`define WAIT_64K 18'h10000
`define WAIT_128K 18'h20000
// ==========================================
// Settling select codes; the top select bit forces the longest wait
`define WAIT_SEL_TOP 2
`define WAIT_CODE_8K 2'h0
`define WAIT_CODE_16K 2'h1
`define WAIT_CODE_32K 2'h2
// ==========================================
// Read bus value outside an answer cycle
`define RDATA_IDLE 8'h00
`endif

// file: testbench/lpm_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Mode, CPU clock and settling wait checker
module lpm_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic sleep_exec,
	input wire logic watch_timer_on,
	input wire logic [2:0] power_mode,
	input wire logic cpu_on_subclock,
	input wire logic [17:0] settle_states
);
	logic [7:0] c [2];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Shadow of both registers; read-only bits are never looked at
	always_ff @(posedge clk or posedge rst)
		if (rst)
			c <= '{8'h00, 8'h00};
		else if (wr && addr < 4'h2)
			c[addr[0]] <= wdata;
	// Sleep request from a given mode with a given standby select
	sequence s_slp(ok, b);
		sleep_exec && ok && c[0][7] == b;
	endsequence
	AST_SLEEP: assert property (s_slp(power_mode < 3'h2, 1'b0) |=> power_mode == 3'h3)
		else $error("no sleep");
	AST_SUBSLEEP: assert property (s_slp(power_mode == 3'h2, 1'b0) |=> power_mode == 3'h4)
		else $error("no subsleep");
	AST_STANDBY: assert property (s_slp(power_mode < 3'h2, 1'b1) |=>
		power_mode == ($past(watch_timer_on) ? 3'h6 : 3'h5)) else $error("no standby");
	AST_WATCH: assert property (s_slp(power_mode == 3'h2, 1'b1) |=> power_mode == 3'h6)
		else $error("no watch");
	AST_MEDIUM: assert property (power_mode < 3'h2 |-> power_mode[0] == $past(c[1][2]))
		else $error("wrong speed");
	AST_LOWSPEED: assert property (cpu_on_subclock == $past(c[0][3]))
		else $error("wrong cpu clock");
	AST_SETTLE: assert property (settle_states ==
		($past(c[0][6]) ? 18'h20000 : 18'h02000 << $past(c[0][5:4]))) else $error("wrong wait");
endmodule // lpm_props
bind low_power_mode_control lpm_props i_props (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .sleep_exec(sleep_exec), .watch_timer_on(watch_timer_on),
	.power_mode(power_mode), .cpu_on_subclock(cpu_on_subclock),
	.settle_states(settle_states));
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench
module tb;
	logic clk, rst, wr, rd, sleep_exec, wake_event, watch_timer_on;
	logic cpu_on_subclock, noise_sample_fast, direct_transfer_on;
	logic [1:0] subactive_div;
	logic [2:0] power_mode;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [17:0] settle_states;
	int fail_count, num_checks;
	low_power_mode_control i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .sleep_exec(sleep_exec), .wake_event(wake_event),
		.watch_timer_on(watch_timer_on), .power_mode(power_mode),
		.cpu_on_subclock(cpu_on_subclock), .settle_states(settle_states),
		.subactive_div(subactive_div), .noise_sample_fast(noise_sample_fast),
		.direct_transfer_on(direct_transfer_on));
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// One bus or core cycle; watch level is held, strobes drop
	task automatic go(input logic [3:0] a, input logic [7:0] d, input logic [4:0] op);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		{watch_timer_on, wr, rd, sleep_exec, wake_event} <= op;
		@(posedge clk);
		{wr, rd, sleep_exec, wake_event} <= 4'h0;
		@(negedge clk);
	endtask
	task automatic ck(input string n, input logic [17:0] e, input logic [17:0] s);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog, far beyond the few dozen cycles needed
	initial begin
		#200000;
		fail_count++;
		stop_test;
	end
	// Tests
	initial begin
		rst = 1'b1;
		{addr, wdata, wr, rd, sleep_exec, wake_event, watch_timer_on} = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		go(4'h0, 8'h00, 5'h04);
		ck("sc1", 18'h00007, rdata);
		ck("settle", 18'h02000, settle_states);
		ck("copies", 18'h00000, {subactive_div, noise_sample_fast, direct_transfer_on});
		go(4'h5, 8'hFF, 5'h08);
		go(4'h5, 8'h00, 5'h04);
		ck("unmapped", 18'h00000, rdata);
		go(4'h1, 8'h1F, 5'h08);
		go(4'h1, 8'h00, 5'h04);
		ck("sc2", 18'h000FF, rdata);
		ck("copies", 18'h0000F, {subactive_div, noise_sample_fast, direct_transfer_on});
		ck("mode", 18'h00001, power_mode);
		go(4'h0, 8'h00, 5'h02);
		ck("mode", 18'h00003, power_mode);
		go(4'h0, 8'h80, 5'h09);
		go(4'h0, 8'h00, 5'h02);
		ck("mode", 18'h00005, power_mode);
		go(4'h0, 8'h00, 5'h11);
		go(4'h0, 8'h00, 5'h12);
		ck("mode", 18'h00006, power_mode);
		$display("test active done");
		go(4'h0, 8'h38, 5'h09);
		go(4'h0, 8'h00, 5'h04);
		ck("sc1", 18'h0003F, rdata);
		ck("mode", 18'h00002, power_mode);
		ck("cpu", 18'h00001, cpu_on_subclock);
		ck("settle", 18'h10000, settle_states);
		go(4'h0, 8'h00, 5'h02);
		ck("mode", 18'h00004, power_mode);
		go(4'h0, 8'hC8, 5'h09);
		go(4'h0, 8'h00, 5'h02);
		ck("mode", 18'h00006, power_mode);
		ck("settle", 18'h20000, settle_states);
		$display("test subclock done");
		stop_test;
	end
endmodule // tb
`default_nettype wire
